// ### hdl/sysbus_pkg.sv
// ============================================================
// shared constants for the processor system bus interface
// ============================================================
package sysbus_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // timing: reference bus cycle and local clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_CYCLE_NS = 1000;
  localparam int BUS_CYCLE_CLKS = BUS_CYCLE_NS / CLK_PERIOD_NS;
  localparam int PHASE_GAP_CLKS = 1;

  // values after reset
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // kind of the bus cycle in progress
  typedef enum logic [1:0] {
    BUS_START,
    BUS_READ,
    BUS_WRITE
  } bus_kind_t;

endpackage

// ### hdl/phase_gen.sv
`timescale 1ns/1ps
// ============================================================
// two-phase non-overlapping clock generator
// ============================================================
module phase_gen
  import sysbus_pkg::*;
#(
  parameter int CYC_CLKS = BUS_CYCLE_CLKS,
  parameter int GAP_CLKS = PHASE_GAP_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  output logic phi1,
  output logic phi2,
  output logic cyc_start,
  output logic ph2_start,
  output logic cyc_end
);

  localparam int CNT_W = $clog2(CYC_CLKS);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(CYC_CLKS / 2);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYC_CLKS - 1);
  localparam logic [CNT_W-1:0] GAP = CNT_W'(GAP_CLKS);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic phi1_r;
  logic phi2_r;

  // strobes announce what the next enabled edge does
  assign cyc_start = (cnt_r == LAST);
  assign ph2_start = (cnt_r == HALF + GAP - 1'b1);
  assign cyc_end = (cnt_r == LAST - GAP);
  assign cnt_nxt = cyc_start ? '0 : cnt_r + 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= LAST - GAP;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  // phase one in the first half, phase two in the second, gaps between
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phi1_r <= 1'b0;
      phi2_r <= 1'b0;
    end else if (ce) begin
      phi1_r <= (cnt_nxt < HALF);
      phi2_r <= (cnt_nxt >= HALF + GAP) && (cnt_nxt <= LAST - GAP);
    end
  end

  assign phi1 = phi1_r;
  assign phi2 = phi2_r;

endmodule

// ### hdl/sysbus_if.sv
`timescale 1ns/1ps
// Contract
// R1: processor alone drives the address bus
// R2: sixteen address outputs, 65,536 locations
// R3: one shared 8-bit bidirectional data bus
// R4: write drives data out, read takes in
// R5: fetches and data share the data bus
// R6: direction high means every transfer reads
// R7: direction low only in write cycles
// R8: two alternating non-overlapping clock phases
// R9: address and direction change in phase one
// R10: data moves only during phase two
// R11: event order fixed; only timing scales
// R12: exactly two interrupt inputs, maskable, non-maskable
// R13: adapters enable and latch interrupt sources
// R14: interrupt lines open-drain, shared, pulled up
// R15: one read or write per bus cycle
module sysbus_if
  import sysbus_pkg::*;
#(
  parameter int CYC_CLKS = BUS_CYCLE_CLKS
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // core request side
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_FETCH,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  // core answer side
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  // core interrupt view
  output logic IRQ_PEND,
  output logic NMI_PEND,
  // bus clocks
  output logic PHI1,
  output logic PHI2,
  // address bus, direction and fetch marker
  output logic [ADDR_W-1:0] ADDR,
  output logic RW,
  output logic SYNC,
  // data bus pin
  input wire logic [DATA_W-1:0] DATA_I,
  output logic [DATA_W-1:0] DATA_O,
  output logic DATA_OE,
  // interrupt request pins
  input wire logic IRQ_N,
  input wire logic NMI_N
);

  // ==========================================================
  // phase generation
  // ==========================================================
  logic cyc_start;
  logic ph2_start;
  logic cyc_end;

  // same sequence for any cycle length
  phase_gen #(
    .CYC_CLKS(CYC_CLKS), // R11
    .GAP_CLKS(PHASE_GAP_CLKS)
  ) u_phase (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .phi1(PHI1), // R8
    .phi2(PHI2),
    .cyc_start(cyc_start),
    .ph2_start(ph2_start),
    .cyc_end(cyc_end)
  );

  // ==========================================================
  // cycle launch
  // ==========================================================
  bus_kind_t kind_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic sync_r;
  logic take;

  // a request is taken only at the start of a bus cycle
  assign REQ_READY = cyc_start & CE; // R15
  assign take = REQ_READY & REQ_VALID;

  // address and kind change at the phase one edge
  always_ff @(posedge CLK or negedge RST_N) begin // R9
    if (!RST_N) begin
      kind_r <= BUS_START;
      addr_r <= ADDR_RST;
      sync_r <= 1'b0;
    end else if (CE && cyc_start) begin
      if (take) begin
        addr_r <= REQ_ADDR; // R1 R2
        kind_r <= REQ_WRITE ? BUS_WRITE : BUS_READ;
        sync_r <= REQ_FETCH & ~REQ_WRITE; // R5
      end else begin
        // idle cycle is a dummy read of the held address
        kind_r <= BUS_READ; // R15
        sync_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdata_r <= DATA_RST;
    end else if (CE && take && REQ_WRITE) begin
      wdata_r <= REQ_WDATA;
    end
  end

  // ==========================================================
  // data phase
  // ==========================================================
  logic oe_r;
  logic rsp_r;
  logic [DATA_W-1:0] rdata_r;
  logic rd_pend_r;

  // reads issued by the core are answered; dummy reads are not
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_pend_r <= 1'b0;
    end else if (CE && cyc_start) begin
      rd_pend_r <= take & ~REQ_WRITE;
    end
  end

  // drive the shared bus only through phase two of a write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_r <= 1'b0;
    end else if (CE) begin
      if (ph2_start && kind_r == BUS_WRITE) begin
        oe_r <= 1'b1; // R3 R4 R10
      end else if (cyc_end) begin
        oe_r <= 1'b0;
      end
    end
  end

  // read data taken at the close of phase two
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_r <= 1'b0;
      rdata_r <= DATA_RST;
    end else if (CE) begin
      rsp_r <= cyc_end && kind_r == BUS_READ && rd_pend_r;
      if (cyc_end && kind_r == BUS_READ) begin
        rdata_r <= DATA_I; // R4 R10
      end
    end
  end

  // ==========================================================
  // interrupt inputs
  // ==========================================================
  logic irq_r;
  logic nmi_r;

  // active low wired-or lines, latched by the adapters
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_r <= 1'b0;
      nmi_r <= 1'b0;
    end else if (CE) begin
      irq_r <= ~IRQ_N; // R12 R14
      nmi_r <= ~NMI_N; // R12
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign ADDR = addr_r;
  assign RW = (kind_r != BUS_WRITE); // R6 R7
  assign SYNC = sync_r;
  assign DATA_O = wdata_r;
  assign DATA_OE = oe_r;
  assign RSP_VALID = rsp_r;
  assign RSP_RDATA = rdata_r;
  assign IRQ_PEND = irq_r;
  assign NMI_PEND = nmi_r;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_phase_excl;
    !(PHI1 && PHI2);
  endproperty
  a_phase_excl: assert property (p_phase_excl) // R8
    else $error("both clock phases high");

  property p_addr_ph1;
    $changed(ADDR) |-> PHI1 && !$past(PHI1);
  endproperty
  a_addr_ph1: assert property (p_addr_ph1) // R9
    else $error("address changed outside phase one start");

  property p_rw_ph1;
    $changed(RW) |-> PHI1;
  endproperty
  a_rw_ph1: assert property (p_rw_ph1) // R9
    else $error("direction changed outside phase one");

  property p_drive_ph2;
    DATA_OE |-> PHI2 && !RW;
  endproperty
  a_drive_ph2: assert property (p_drive_ph2) // R10
    else $error("data driven outside write phase two");

  property p_write_launch;
    $past(CE) && $past(take && REQ_WRITE)
      |-> !RW && ADDR == $past(REQ_ADDR) && DATA_O == $past(REQ_WDATA);
  endproperty
  a_write_launch: assert property (p_write_launch) // R7
    else $error("write request not launched");

  property p_read_launch;
    $past(CE) && $past(take && !REQ_WRITE) |-> RW && ADDR == $past(REQ_ADDR);
  endproperty
  a_read_launch: assert property (p_read_launch) // R6
    else $error("read request not launched");

  property p_one_rsp;
    RSP_VALID && $past(CE) |-> RW && $past(PHI2) && !PHI2;
  endproperty
  a_one_rsp: assert property (p_one_rsp) // R15
    else $error("answer outside read cycle end");

  property p_rsp_data;
    $past(CE) && RSP_VALID |-> RSP_RDATA == $past(DATA_I);
  endproperty
  a_rsp_data: assert property (p_rsp_data) // R4
    else $error("answer data not sampled bus data");

  property p_sync_read;
    SYNC |-> RW;
  endproperty
  a_sync_read: assert property (p_sync_read) // R5
    else $error("fetch marker on a write");

  property p_irq_follow;
    $past(CE) |-> IRQ_PEND == !$past(IRQ_N) && NMI_PEND == !$past(NMI_N);
  endproperty
  a_irq_follow: assert property (p_irq_follow) // R12
    else $error("interrupt level not followed");

  c_write: cover property (DATA_OE && CE);
  c_read_rsp: cover property (RSP_VALID && SYNC);
  c_wr_rd: cover property (!RW ##[1:300] RSP_VALID);
  c_nmi: cover property (NMI_PEND && IRQ_PEND);

endmodule

// ### bench/mem_model.sv
`timescale 1ns/1ps
// ============================================================
// memory partner on the far side of the data bus
// ============================================================
module mem_model
  import sysbus_pkg::*;
(
  // bus view
  input wire logic clk,
  input wire logic phi2,
  input wire logic rw,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe,
  output logic [DATA_W-1:0] data_i
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  bit written [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] junk = 8'h5a;
  always @(posedge clk) begin
    if (phi2 && data_oe) begin
      mem[addr] <= data_o;
      written[addr] <= 1'b1;
    end
  end
  // drive only in phase two of a read, changing garbage otherwise
  always @(phi2, rw, addr) begin
    junk = ~junk;
    if (phi2 && rw) begin
      data_i = written[addr] ? mem[addr] : addr[15:8] ^ addr[7:0];
    end else begin
      data_i = junk;
    end
  end
endmodule

// ### bench/tb_processor_system_bus_interface.sv
`timescale 1ns/1ps
// ============================================================
// bench for the processor system bus interface
// ============================================================
module tb_processor_system_bus_interface
  import sysbus_pkg::*;
;
  localparam int N = 10;
  logic CLK = 0;
  logic RST_N = 0;
  logic REQ_VALID = 0, REQ_WRITE = 0, REQ_FETCH = 0;
  logic [ADDR_W-1:0] REQ_ADDR = '0, ADDR, last_a = '0;
  logic [DATA_W-1:0] REQ_WDATA = '0, RSP_RDATA, DATA_I, DATA_O;
  logic REQ_READY, RSP_VALID, PHI1, PHI2, RW, SYNC, DATA_OE;
  logic IRQ_PEND, NMI_PEND;
  logic irq_a_n = 1, irq_b_n = 1, NMI_N = 1;
  logic CE = 1;
  int errors = 0, samples_checked = 0;
  // two open-drain sources share one pulled-up line
  wire IRQ_N = irq_a_n & irq_b_n;
  always #5 CLK = ~CLK;

  sysbus_if #(.CYC_CLKS(N)) u_dut (.CLK, .RST_N, .CE, .REQ_VALID,
    .REQ_WRITE, .REQ_FETCH, .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RSP_VALID,
    .RSP_RDATA, .IRQ_PEND, .NMI_PEND, .PHI1, .PHI2, .ADDR, .RW, .SYNC,
    .DATA_I, .DATA_O, .DATA_OE, .IRQ_N, .NMI_N);
  mem_model u_mem (.clk(CLK), .phi2(PHI2), .rw(RW), .addr(ADDR),
    .data_o(DATA_O), .data_oe(DATA_OE), .data_i(DATA_I));

  // ============================================================
  // shared tasks
  // ============================================================
  task automatic step();
    @(posedge CLK);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one whole bus cycle, checked at every clock
  task automatic xfer(input logic v, w, f, input logic [15:0] a,
                      input logic [7:0] d, exp);
    logic rd;
    int k;
    rd = !(v && w);
    for (k = 0; REQ_READY !== 1'b1; k++) begin
      if (k > 2 * N) begin
        errors++;
        end_of_test();
      end
      step();
    end
    REQ_VALID = v;
    REQ_WRITE = w;
    REQ_FETCH = f;
    REQ_ADDR = a;
    REQ_WDATA = d;
    if (v)
      last_a = a;
    step();
    REQ_VALID = 0;
    for (k = 0; k < N; k++) begin
      chk(ADDR, last_a, "addr");
      chk(RW, rd, "dir");
      chk(PHI1, k < N / 2, "phase one");
      chk(PHI2, k > N / 2 && k < N - 1, "phase two");
      chk(DATA_OE, !rd && k > N / 2 && k < N - 1, "drive");
      if (!rd)
        chk(DATA_O, d, "wdata");
      chk(SYNC, v && rd && f, "fetch");
      chk(RSP_VALID, v && rd && k == N - 1, "answer");
      chk(REQ_READY, k == N - 1, "ready");
      if (k < N - 1)
        step();
    end
    if (v && rd)
      chk(RSP_RDATA, exp, "rdata");
  endtask

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_reset();
    RST_N = 0;
    repeat (10) step();
    chk(ADDR, 16'h0000, "rst addr");
    chk(RW, 1'b1, "rst dir");
    chk(DATA_OE, 1'b0, "rst drive");
    chk(PHI1 | PHI2, 1'b0, "rst phase");
    RST_N = 1;
    $display("reset test done");
  endtask

  task automatic t_read();
    xfer(1, 0, 1, 16'hff0f, 8'h00, 8'hf0);
    xfer(1, 0, 0, 16'h1234, 8'h00, 8'h26);
    $display("read test done");
  endtask

  task automatic t_write();
    xfer(1, 1, 1, 16'h8001, 8'ha5, 8'h00);
    xfer(1, 0, 0, 16'h8001, 8'h00, 8'ha5);
    xfer(0, 0, 0, 16'h0000, 8'h00, 8'h00);
    $display("write test done");
  endtask

  // a request offered while frozen must not be taken
  task automatic t_freeze();
    logic [15:0] a;
    logic [1:0] ph;
    a = ADDR;
    ph = {PHI1, PHI2};
    CE = 0;
    REQ_VALID = 1;
    REQ_WRITE = 0;
    REQ_FETCH = 0;
    REQ_ADDR = 16'h00ff;
    repeat (3) begin
      step();
      chk(REQ_READY, 1'b0, "frozen ready");
      chk(ADDR, a, "frozen addr");
      chk({PHI1, PHI2}, ph, "frozen phase");
    end
    CE = 1;
    xfer(1, 0, 0, 16'h00ff, 8'h00, 8'hff);
    $display("freeze test done");
  endtask

  task automatic t_irq();
    irq_a_n = 0;
    step();
    chk(IRQ_PEND, 1'b1, "irq");
    chk(NMI_PEND, 1'b0, "nmi quiet");
    irq_a_n = 1;
    irq_b_n = 0;
    NMI_N = 0;
    step();
    chk(IRQ_PEND, 1'b1, "irq shared");
    chk(NMI_PEND, 1'b1, "nmi");
    irq_b_n = 1;
    NMI_N = 1;
    step();
    chk(IRQ_PEND, 1'b0, "irq clear");
    chk(NMI_PEND, 1'b0, "nmi clear");
    $display("irq test done");
  endtask

  initial begin
    t_reset();
    t_read();
    t_write();
    t_freeze();
    t_irq();
    end_of_test();
  end
endmodule
